// File: dv/board_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_mcu_model (
  // Clock and scenario controls; strap 0 open, 1 pull-up, 2 capacitor
  input wire logic clk_i,
  input wire logic [1:0] strap_i,
  input wire logic [15:0] cap_cyc_i,
  input wire logic [15:0] kick_per_i,
  // Device pins
  input wire logic wchg_i,
  input wire logic dchg_i,
  output logic kick_o,
  output logic wcmp_o,
  output logic dcmp_o
);
  int wc = 0;
  int dc = 0;
  int kc = 0;
  initial kick_o = 1'b1;
  // Kick pulses low for ten cycles once per period; zero period stops
  always @(posedge clk_i) begin
    wc <= wchg_i ? wc + 1 : 0;
    dc <= dchg_i ? dc + 1 : 0;
    kc <= (kick_per_i == 16'h0 || kc >= kick_per_i) ? 0 : kc + 1;
    kick_o <= !(kick_per_i != 16'h0 && kc < 10);
  end
  assign wcmp_o = strap_i == 2'h1 ||
    (wchg_i && wc >= (strap_i == 2'h2 ? cap_cyc_i : 16'h5));
  assign dcmp_o = dchg_i && dc >= 5;
endmodule : board_mcu_model
`default_nettype wire

// File: dv/tb_window_watchdog_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "window_watchdog_timing_params.svh"
module tb_window_watchdog_timing;
  localparam logic [31:0] NLO = 32'h190;
  localparam logic [31:0] NHI = 32'h320;
  localparam logic [31:0] PLO = 32'h96;
  localparam logic [31:0] PHI = 32'h12c;
  localparam logic [31:0] HOLD = 32'h1388;
  localparam logic [31:0] OFS = 32'hc8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic ratio_select_0_i = 1'b1;
  logic ratio_select_1_i = 1'b1;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, q;
  logic pready_o, pslverr_o, e, kick_input_i, window_cap_pin_cmp_i;
  logic window_cap_pin_dis_o, window_cap_pin_chg_o, delay_cap_pin_cmp_i;
  logic delay_cap_pin_dis_o, delay_cap_pin_chg_o, irq_o;
  logic fault_output_n_o, fault_output_n_oe_o;
  logic [1:0] strap = 2'h0;
  logic [15:0] kper = 16'h0;
  int mismatches = 0;
  int check_count = 0;
  int n;
  window_watchdog_timing #(.NC11_LO(NLO), .NC11_HI(NHI), .PU11_LO(PLO),
    .PU11_HI(PHI), .RST_NC(HOLD), .RST_PU(32'hfa0), .WCAP_OFS(OFS),
    .CHG_MAX(32'h4e20)) dut (.clk_i, .rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .kick_input_i, .ratio_select_0_i, .ratio_select_1_i,
    .window_cap_pin_cmp_i, .window_cap_pin_dis_o, .window_cap_pin_chg_o,
    .delay_cap_pin_cmp_i, .delay_cap_pin_dis_o, .delay_cap_pin_chg_o,
    .fault_output_n_o, .fault_output_n_oe_o, .irq_o);
  board_mcu_model bm (.clk_i, .strap_i(strap), .cap_cyc_i(16'h3e8),
    .kick_per_i(kper), .wchg_i(window_cap_pin_chg_o),
    .dchg_i(delay_cap_pin_chg_o), .kick_o(kick_input_i),
    .wcmp_o(window_cap_pin_cmp_i), .dcmp_o(delay_cap_pin_cmp_i));
  initial forever #50 clk_i = ~clk_i;
  task automatic report_and_stop;
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] x, y);
    check_count++;
    if (y !== x) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, x, y);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= 32'(d);
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k >= 20) begin
      mismatches++;
      report_and_stop();
    end
  endtask : apb
  task automatic wait_oe(input logic v, input int lim);
    n = 0;
    while (fault_output_n_oe_o !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (fault_output_n_oe_o !== v) begin
      mismatches++;
      $display("[ERR] fault_oe exp %h got %h", v, fault_output_n_oe_o);
      report_and_stop();
    end
  endtask : wait_oe
  // Counts the cycles in which the fault output is driven
  task automatic watch_oe(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      if (fault_output_n_oe_o !== 1'b0) begin
        n++;
      end
    end
  endtask : watch_oe
  task automatic s_good;
    apb(1'b0, 8'h08, 0);
    chk("irq_en", 32'h0, q);
    apb(1'b0, 8'h40, 0);
    chk("slverr", 32'h1, 32'(e));
    // Bounds are loaded only once the open strap has been detected
    repeat (110) @(posedge clk_i);
    apb(1'b0, 8'h14, 0);
    chk("lower", NLO, q);
    apb(1'b0, 8'h10, 0);
    chk("upper", NHI, q);
    repeat (417) @(posedge clk_i);
    kper <= 16'h257;
    watch_oe(5000);
    chk("good kicks", 32'h0, 32'(n));
    apb(1'b0, 8'h00, 0);
    chk("status", 32'h4, q & 32'h7);
  endtask : s_good
  task automatic s_fault;
    apb(1'b1, 8'h04, 32'hf);
    apb(1'b1, 8'h08, 32'h1);
    kper <= 16'hc7;
    wait_oe(1'b1, 1000);
    kper <= 16'h0;
    strap <= 2'h1;
    chk("early", 32'h1, 32'(n < 1000));
    chk("irq", 32'h1, 32'(irq_o));
    wait_oe(1'b0, 6000);
    chk("hold", 32'h1, 32'(n > HOLD - 20 && n <= HOLD));
    apb(1'b0, 8'h00, 0);
    chk("status", 32'h9, q & 32'hf);
    apb(1'b1, 8'h04, 32'h1);
    repeat (110) @(posedge clk_i);
    chk("irq clr", 32'h0, 32'(irq_o));
    apb(1'b0, 8'h14, 0);
    chk("pu lower", PLO, q);
    apb(1'b0, 8'h10, 0);
    chk("pu upper", PHI, q);
    apb(1'b0, 8'h0c, 0);
    chk("straps", 32'h1, q & 32'hf);
    wait_oe(1'b1, 400);
    chk("late", 32'h1, 32'(n < 400));
    apb(1'b0, 8'h00, 0);
    chk("late bit", 32'h2, q & 32'h2);
    chk("irq mask", 32'h0, 32'(irq_o));
  endtask : s_fault
  task automatic s_cap;
    logic [1:0] cd [3] = '{2'h0, 2'h1, 2'h3};
    int num [3] = '{1, 3, 1};
    int den [3] = '{8, 4, 2};
    logic [31:0] lo, hi, u, a, b;
    lo = ((1000 * `WCAP_GAIN_Q8) >> 8) + OFS;
    hi = ((1010 * `WCAP_GAIN_Q8) >> 8) + OFS;
    strap <= 2'h2;
    for (int i = 0; i < 3; i++) begin
      {ratio_select_0_i, ratio_select_1_i} <= 2'h2;
      repeat (20) @(posedge clk_i);
      chk("off", 32'h0, 32'(fault_output_n_oe_o));
      {ratio_select_0_i, ratio_select_1_i} <= cd[i];
      repeat (1300) @(posedge clk_i);
      apb(1'b0, 8'h10, 0);
      u = q;
      chk("cap upper", 32'h1, 32'(u >= lo && u <= hi));
      apb(1'b0, 8'h14, 0);
      a = u * num[i];
      b = q * den[i];
      chk("ratio", 32'h1, 32'(b < a + den[i] && a < b + den[i]));
    end
    {ratio_select_0_i, ratio_select_1_i} <= 2'h2;
    // Longer than the running capacitor window, so a lost disable trips
    watch_oe(30000);
    chk("disabled", 32'h0, 32'(n));
  endtask : s_cap
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    s_good();
    s_fault();
    s_cap();
    report_and_stop();
  end
endmodule : tb_window_watchdog_timing
`default_nettype wire

// File: dv/wdt_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "window_watchdog_timing_params.svh"
module wdt_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pins seen at the top
  input wire logic ratio_select_0_i,
  input wire logic ratio_select_1_i,
  input wire logic window_cap_pin_dis_o,
  input wire logic window_cap_pin_chg_o,
  input wire logic window_cap_pin_cmp_i,
  input wire logic delay_cap_pin_dis_o,
  input wire logic delay_cap_pin_chg_o,
  input wire logic fault_output_n_o,
  input wire logic fault_output_n_oe_o
);
  logic [31:0] hold_r;
  logic [31:0] hold_nxt;
  wire logic sel_off = ratio_select_0_i & ~ratio_select_1_i;
  always_comb begin
    hold_nxt = fault_output_n_oe_o ? hold_r + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_i) begin
    hold_r <= rst_i ? 32'h0 : hold_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_OE_PAIR: assert property (
    fault_output_n_o != fault_output_n_oe_o) else $error("fault pin pair");
  // Disable releases at once, so only a normal release is timed
  AST_HOLD_MIN: assert property (
    $fell(fault_output_n_oe_o) && !sel_off && !$past(rst_i)
    |-> hold_r >= `INIT_CYC) else $error("fault released early");
  AST_INIT_DIS: assert property (
    $rose(fault_output_n_oe_o) |-> ##[0:1] delay_cap_pin_dis_o [*8])
    else $error("delay pin not discharged");
  AST_DLY_EXCL: assert property (
    !(delay_cap_pin_dis_o && delay_cap_pin_chg_o)) else $error("delay both");
  // Threshold seen through the pin filter ends charging on the next edge
  AST_WCAP_STOP: assert property (
    (window_cap_pin_chg_o && window_cap_pin_cmp_i) [*5]
    |=> !window_cap_pin_chg_o) else $error("window charge not stopped");
  AST_OFF: assert property (
    sel_off [*8] |-> !fault_output_n_oe_o) else $error("fault while off");
  AST_RESTART: assert property (
    $fell(fault_output_n_oe_o) |-> ##[0:1] window_cap_pin_dis_o)
    else $error("window not restarted");
  AST_RESET: assert property (disable iff (1'b0)
    rst_i |=> !fault_output_n_oe_o) else $error("fault after reset");
endmodule : wdt_monitor
bind window_watchdog_timing wdt_monitor mon (.clk_i, .rst_i,
  .ratio_select_0_i, .ratio_select_1_i, .window_cap_pin_dis_o,
  .window_cap_pin_chg_o, .window_cap_pin_cmp_i, .delay_cap_pin_dis_o,
  .delay_cap_pin_chg_o,
  .fault_output_n_o, .fault_output_n_oe_o);
`default_nettype wire

// File: verilog/wdt_pkg.sv
package wdt_pkg;

  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_DIS = 7'h02,
    ST_CHG = 7'h04,
    ST_WIN = 7'h08,
    ST_FINIT = 7'h10,
    ST_FCHG = 7'h20,
    ST_FHOLD = 7'h40
  } wd_state_t;

  typedef enum logic [1:0] {
    STRAP_OPEN = 2'h0,
    STRAP_PULLUP = 2'h1,
    STRAP_CAP = 2'h2
  } strap_t;

endpackage : wdt_pkg

// File: verilog/window_watchdog_timing.sv
// Contract
// - Cap upper bound is 77.4*C plus 0.055 s
// - Upper bound ends when charged pin trips comparator
// - Lower bound ratio 1/8, 3/4, 1/2; 10 disables
// - Bounds follow cap strap and both selects
// - Early or late kick drives fault low
// - Missing kick holds fault for reset delay
// - Faults repeat until good kicks release output
// - Open pin, selects high: 800 ms / 1.6 s
// - Each fault re-detects delay strap, fixed length
// - Open or pulled-up pin uses factory bounds
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "window_watchdog_timing_params.svh"
module window_watchdog_timing #(
  parameter logic [31:0] NC00_LO = `NC00_LO_US * `CLK_MHZ,
  parameter logic [31:0] NC00_HI = `NC00_HI_US * `CLK_MHZ,
  parameter logic [31:0] NC01_LO = `NC01_LO_US * `CLK_MHZ,
  parameter logic [31:0] NC01_HI = `NC01_HI_US * `CLK_MHZ,
  parameter logic [31:0] NC11_LO = `NC11_LO_US * `CLK_MHZ,
  parameter logic [31:0] NC11_HI = `NC11_HI_US * `CLK_MHZ,
  parameter logic [31:0] PU00_LO = `PU00_LO_US * `CLK_MHZ,
  parameter logic [31:0] PU00_HI = `PU00_HI_US * `CLK_MHZ,
  parameter logic [31:0] PU01_LO = `PU01_LO_US * `CLK_MHZ,
  parameter logic [31:0] PU01_HI = `PU01_HI_US * `CLK_MHZ,
  parameter logic [31:0] PU11_LO = `PU11_LO_US * `CLK_MHZ,
  parameter logic [31:0] PU11_HI = `PU11_HI_US * `CLK_MHZ,
  parameter logic [31:0] RST_NC = `RST_NC_US * `CLK_MHZ,
  parameter logic [31:0] RST_PU = `RST_PU_US * `CLK_MHZ,
  parameter logic [31:0] WCAP_OFS = `WCAP_OFS_US * `CLK_MHZ,
  parameter logic [31:0] CHG_MAX = `CHG_MAX_US * `CLK_MHZ
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Supervised side and select pins
  input wire logic kick_input_i,
  input wire logic ratio_select_0_i,
  input wire logic ratio_select_1_i,
  // Window capacitor pin front end
  input wire logic window_cap_pin_cmp_i,
  output logic window_cap_pin_dis_o,
  output logic window_cap_pin_chg_o,
  // Delay capacitor pin front end
  input wire logic delay_cap_pin_cmp_i,
  output logic delay_cap_pin_dis_o,
  output logic delay_cap_pin_chg_o,
  // Open-drain fault output
  output logic fault_output_n_o,
  output logic fault_output_n_oe_o,
  // Interrupt
  output logic irq_o
);

  wdt_pkg::wd_state_t state_r, state_nxt;
  wdt_pkg::strap_t wmode_r, wmode_nxt, dmode_r, dmode_nxt;
  logic [31:0] wcnt_r, wcnt_nxt, fcnt_r, fcnt_nxt;
  logic [31:0] lo_r, lo_nxt, hi_r, hi_nxt;
  logic fault_r, fault_nxt;
  logic [3:0] status_r, status_nxt, irq_en_r, irq_en_nxt;
  logic [4:0] pin_raw, s1_r, s2_r, s3_r, flt_r, flt_nxt;
  logic ev_early, ev_late, ev_ok, ev_rel;
  logic kick_fall, disabled, wcap_cmp, dcap_cmp;
  logic [1:0] sel;
  logic [31:0] chg_cnt, rst_len;
  logic [47:0] prod;
  logic acc, wr;
  logic [3:0] clr;

  function automatic logic [31:0] fac_bound(
    input wdt_pkg::strap_t m,
    input logic [1:0] s,
    input logic up
  );
    logic [31:0] v;
    v = 32'h0;
    if (m == wdt_pkg::STRAP_PULLUP) begin
      case (s)
        2'b00: v = up ? PU00_HI : PU00_LO;
        2'b01: v = up ? PU01_HI : PU01_LO;
        default: v = up ? PU11_HI : PU11_LO;
      endcase
    end else begin
      case (s)
        2'b00: v = up ? NC00_HI : NC00_LO;
        2'b01: v = up ? NC01_HI : NC01_LO;
        default: v = up ? NC11_HI : NC11_LO;
      endcase
    end
    return v;
  endfunction : fac_bound

  function automatic logic [31:0] ratio_lo(
    input logic [31:0] u,
    input logic [1:0] s
  );
    logic [31:0] v;
    v = 32'h0;
    case (s)
      2'b00: v = u >> 3;
      2'b01: v = u - (u >> 2);
      default: v = u >> 1;
    endcase
    return v;
  endfunction : ratio_lo

  // Pin synchronisers; stage one feeds only stage two
  assign pin_raw = {delay_cap_pin_cmp_i, window_cap_pin_cmp_i,
                    ratio_select_1_i, ratio_select_0_i, kick_input_i};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_filt
      assign flt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s2_r[gi] : flt_r[gi];
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
      flt_r <= 5'h00;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flt_r <= flt_nxt;
    end
  end

  // A kick is the falling edge of the filtered input
  assign kick_fall = flt_r[0] & ~flt_nxt[0];
  assign sel = {flt_r[1], flt_r[2]};
  assign wcap_cmp = flt_r[3];
  assign dcap_cmp = flt_r[4];
  assign disabled = (sel == 2'b10);
  assign chg_cnt = wcnt_r - 32'(`DIS_CYC);
  assign prod = 48'(chg_cnt) * 48'(`WCAP_GAIN_Q8);
  assign rst_len = (dmode_r == wdt_pkg::STRAP_PULLUP) ? RST_PU : RST_NC;

  always_comb begin
    state_nxt = state_r;
    wcnt_nxt = wcnt_r + 32'h1;
    fcnt_nxt = fcnt_r;
    wmode_nxt = wmode_r;
    dmode_nxt = dmode_r;
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    fault_nxt = fault_r;
    ev_early = 1'b0;
    ev_late = 1'b0;
    ev_ok = 1'b0;
    ev_rel = 1'b0;
    unique case (state_r)
      wdt_pkg::ST_OFF: begin
        wcnt_nxt = 32'h0;
        state_nxt = wdt_pkg::ST_DIS;
      end
      // Every lower bound exceeds the strap and charge phases
      wdt_pkg::ST_DIS: begin
        if (kick_fall) begin
          ev_early = 1'b1;
        end else if (wcnt_r >= 32'(`DIS_CYC - 1)) begin
          if (wcap_cmp) begin
            wmode_nxt = wdt_pkg::STRAP_PULLUP;
            lo_nxt = fac_bound(wdt_pkg::STRAP_PULLUP, sel, 1'b0);
            hi_nxt = fac_bound(wdt_pkg::STRAP_PULLUP, sel, 1'b1);
            state_nxt = wdt_pkg::ST_WIN;
          end else begin
            state_nxt = wdt_pkg::ST_CHG;
          end
        end
      end
      wdt_pkg::ST_CHG: begin
        if (kick_fall) begin
          ev_early = 1'b1;
        end else if (wcap_cmp) begin
          state_nxt = wdt_pkg::ST_WIN;
          if (chg_cnt < 32'(`DET_CYC)) begin
            wmode_nxt = wdt_pkg::STRAP_OPEN;
            lo_nxt = fac_bound(wdt_pkg::STRAP_OPEN, sel, 1'b0);
            hi_nxt = fac_bound(wdt_pkg::STRAP_OPEN, sel, 1'b1);
          end else begin
            wmode_nxt = wdt_pkg::STRAP_CAP;
            hi_nxt = prod[39:8] + WCAP_OFS;
            lo_nxt = ratio_lo(prod[39:8] + WCAP_OFS, sel);
          end
        end else if (chg_cnt >= CHG_MAX) begin
          // Pin shorted or capacitor far too large
          ev_late = 1'b1;
        end
      end
      wdt_pkg::ST_WIN: begin
        if (kick_fall) begin
          if (wcnt_r < lo_r) begin
            ev_early = 1'b1;
          end else begin
            ev_ok = 1'b1;
            wcnt_nxt = 32'h0;
            state_nxt = wdt_pkg::ST_DIS;
          end
        end else if (wcnt_r >= hi_r) begin
          ev_late = 1'b1;
        end
      end
      // Pull-down first half, then source current; fixed length
      wdt_pkg::ST_FINIT: begin
        fcnt_nxt = fcnt_r + 32'h1;
        if (fcnt_r == 32'(`INIT_HALF_CYC - 1) && dcap_cmp) begin
          dmode_nxt = wdt_pkg::STRAP_PULLUP;
        end
        if (fcnt_r == 32'(`INIT_CYC - 1)) begin
          if (dmode_r == wdt_pkg::STRAP_PULLUP) begin
            state_nxt = wdt_pkg::ST_FHOLD;
          end else if (dcap_cmp) begin
            dmode_nxt = wdt_pkg::STRAP_OPEN;
            state_nxt = wdt_pkg::ST_FHOLD;
          end else begin
            state_nxt = wdt_pkg::ST_FCHG;
          end
        end
      end
      wdt_pkg::ST_FCHG: begin
        fcnt_nxt = fcnt_r + 32'h1;
        ev_rel = dcap_cmp;
      end
      wdt_pkg::ST_FHOLD: begin
        fcnt_nxt = fcnt_r + 32'h1;
        ev_rel = (fcnt_r >= rst_len - 32'h1);
      end
      default: begin
        state_nxt = wdt_pkg::ST_OFF;
      end
    endcase
    if (ev_early | ev_late) begin
      state_nxt = wdt_pkg::ST_FINIT;
      fcnt_nxt = 32'h0;
      fault_nxt = 1'b1;
      dmode_nxt = wdt_pkg::STRAP_CAP;
    end
    if (ev_rel) begin
      state_nxt = wdt_pkg::ST_DIS;
      wcnt_nxt = 32'h0;
      fault_nxt = 1'b0;
    end
    if (disabled) begin
      state_nxt = wdt_pkg::ST_OFF;
      wcnt_nxt = 32'h0;
      fault_nxt = 1'b0;
    end
  end

  // Register bus; set beats clear on the same cycle
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i;
  assign clr = (wr && paddr_i == `REG_CLEAR) ? pwdata_i[3:0] : 4'h0;

  always_comb begin
    status_nxt = status_r & ~clr;
    status_nxt[`ST_EARLY] = status_nxt[`ST_EARLY] | ev_early;
    status_nxt[`ST_LATE] = status_nxt[`ST_LATE] | ev_late;
    status_nxt[`ST_OK] = status_nxt[`ST_OK] | ev_ok;
    status_nxt[`ST_REL] = status_nxt[`ST_REL] | ev_rel;
    irq_en_nxt = irq_en_r;
    if (wr && paddr_i == `REG_IRQ_EN) begin
      irq_en_nxt = pwdata_i[3:0];
    end
  end

  always_comb begin
    prdata_o = 32'h0;
    pslverr_o = 1'b0;
    case (paddr_i)
      `REG_STATUS: prdata_o = {28'h0, status_r};
      `REG_CLEAR: prdata_o = 32'h0;
      `REG_IRQ_EN: prdata_o = {28'h0, irq_en_r};
      `REG_STATE: prdata_o = {18'h0, state_r, sel, fault_r, dmode_r,
                              wmode_r};
      `REG_UPPER: prdata_o = hi_r;
      `REG_LOWER: prdata_o = lo_r;
      default: pslverr_o = acc;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= wdt_pkg::ST_OFF;
      wmode_r <= wdt_pkg::STRAP_OPEN;
      dmode_r <= wdt_pkg::STRAP_OPEN;
      wcnt_r <= 32'h0;
      fcnt_r <= 32'h0;
      lo_r <= 32'h0;
      hi_r <= 32'h0;
      fault_r <= 1'b0;
      status_r <= 4'h0;
      irq_en_r <= `IRQ_EN_RST;
    end else begin
      state_r <= state_nxt;
      wmode_r <= wmode_nxt;
      dmode_r <= dmode_nxt;
      wcnt_r <= wcnt_nxt;
      fcnt_r <= fcnt_nxt;
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      fault_r <= fault_nxt;
      status_r <= status_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  assign pready_o = 1'b1;
  assign irq_o = |(status_r & irq_en_r);
  assign fault_output_n_o = ~fault_r;
  assign fault_output_n_oe_o = fault_r;
  assign window_cap_pin_chg_o = (state_r == wdt_pkg::ST_CHG);
  assign window_cap_pin_dis_o = (state_r != wdt_pkg::ST_CHG);
  assign delay_cap_pin_dis_o = (state_r == wdt_pkg::ST_FINIT) &&
                               (fcnt_r < 32'(`INIT_HALF_CYC));
  assign delay_cap_pin_chg_o = (state_r == wdt_pkg::ST_FCHG) ||
                               ((state_r == wdt_pkg::ST_FINIT) &&
                                (fcnt_r >= 32'(`INIT_HALF_CYC)));

endmodule : window_watchdog_timing
`default_nettype wire

// File: verilog/window_watchdog_timing_params.svh
`ifndef WINDOW_WATCHDOG_TIMING_PARAMS_SVH
`define WINDOW_WATCHDOG_TIMING_PARAMS_SVH

`define CLK_MHZ 10

// Factory window bounds in microseconds, open strap then pull-up strap
`define NC00_LO_US 22500
`define NC00_HI_US 55000
`define NC01_LO_US 1850
`define NC01_HI_US 27500
`define NC11_LO_US 800000
`define NC11_HI_US 1600000
`define PU00_LO_US 9000
`define PU00_HI_US 109000
`define PU01_LO_US 9000
`define PU01_HI_US 195000
`define PU11_LO_US 1850
`define PU11_HI_US 11000

// Fault hold for the factory delay straps
`define RST_NC_US 200000
`define RST_PU_US 10000

// Delay strap detection sequence
`define INIT_US 381
`define INIT_CYC (`INIT_US * `CLK_MHZ)
`define INIT_HALF_CYC (`INIT_CYC / 2)

// Window capacitor discharge time and open-pin detect limit
`define DIS_US 10
`define DIS_CYC (`DIS_US * `CLK_MHZ)
`define DET_US 10
`define DET_CYC (`DET_US * `CLK_MHZ)
// Longest charge accepted; about 1 uF plus margin
`define CHG_MAX_US 4000000

// Capacitor upper bound: slope in s/uF times ten, offset, charge physics
`define WCAP_SLOPE_X10 774
`define WCAP_OFS_US 55000
`define WCAP_ICHG_NA 375
`define WCAP_VTH_MV 1210
`define WCAP_GAIN_Q8 \
  ((`WCAP_SLOPE_X10 * `WCAP_ICHG_NA * 256) / (`WCAP_VTH_MV * 10))

// Register byte offsets
`define REG_STATUS 8'h00
`define REG_CLEAR 8'h04
`define REG_IRQ_EN 8'h08
`define REG_STATE 8'h0c
`define REG_UPPER 8'h10
`define REG_LOWER 8'h14

// Status bits and reset values
`define ST_EARLY 0
`define ST_LATE 1
`define ST_OK 2
`define ST_REL 3
`define IRQ_EN_RST 4'h0

`endif
